// File: bench/pfk_ctrl_props.sv
// Purpose: port assertions for the function key controller
// Assumes: sees the top ports only
// Notes: bound at the foot
module pfk_ctrl_props (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic [8:0] func_key_i,
	input wire logic trip_pb_i,
	input wire logic close_pb_i,
	input wire logic hot_tag_i,
	input wire logic [8:0] key_led_o,
	input wire logic ground_sense_inhibit_o,
	input wire logic reclose_inhibit_o,
	input wire logic sup_off_o,
	input wire logic [1:0] profile_o,
	input wire logic fast_curve_en_o,
	input wire logic delayed_curve_only_o,
	input wire logic trip_o,
	input wire logic close_o,
	input wire logic hot_tag_o,
	input wire logic disc_rejected_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	logic [3:0] sup_age_r;
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			sup_age_r <= 4'hF;
		else if (func_key_i[2])
			sup_age_r <= 4'h0;
		else if (sup_age_r != 4'hF)
			sup_age_r <= sup_age_r + 4'h1;
	end
	property p_led_gnd; key_led_o[0] == ground_sense_inhibit_o; endproperty
	a_led_gnd: assert property (p_led_gnd)
		else $error("ground led mismatch");
	property p_led_nrc; key_led_o[1] == reclose_inhibit_o; endproperty
	a_led_nrc: assert property (p_led_nrc)
		else $error("reclose led mismatch");
	property p_led_sup; key_led_o[2] == sup_off_o; endproperty
	a_led_sup: assert property (p_led_sup)
		else $error("sup led mismatch");
	property p_prof;
		key_led_o[3] == (profile_o == 2'h1) && key_led_o[4] == (profile_o == 2'h2)
			&& key_led_o[5] == (profile_o == 2'h3);
	endproperty
	a_prof: assert property (p_prof)
		else $error("profile led mismatch");
	property p_curve; fast_curve_en_o != delayed_curve_only_o; endproperty
	a_curve: assert property (p_curve)
		else $error("curve select mismatch");
	property p_pass;
		trip_o == trip_pb_i && close_o == close_pb_i && hot_tag_o == hot_tag_i;
	endproperty
	a_pass: assert property (p_pass)
		else $error("pushbutton path mismatch");
	property p_sup_src; $changed(sup_off_o) |-> sup_age_r <= 4'h8; endproperty
	a_sup_src: assert property (p_sup_src)
		else $error("sup off changed without panel key");
	property p_rej; disc_rejected_o |-> sup_off_o ##1 !disc_rejected_o; endproperty
	a_rej: assert property (p_rej)
		else $error("discrete reject bad");
endmodule // pfk_ctrl_props
bind pfk_ctrl pfk_ctrl_props props_u (.mclk_i, .rstn_i, .func_key_i,
	.trip_pb_i, .close_pb_i, .hot_tag_i, .key_led_o, .ground_sense_inhibit_o,
	.reclose_inhibit_o, .sup_off_o, .profile_o, .fast_curve_en_o,
	.delayed_curve_only_o, .trip_o, .close_o, .hot_tag_o, .disc_rejected_o);

// File: bench/pfk_ctrl_tb_top.sv
// Purpose: self-checking bench for the function key controller
// Assumes: short change window of 50 cycles
// Notes: integer model compared at every result
module pfk_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_i = 0, rstn_i = 0, psel = 0, pen = 0, pwr = 0, go = 0;
	logic trip = 0, clo = 0, hot = 0, chg, err;
	int seen_rej = 0;
	logic [9:1] ofe;
	logic [11:0] pa = 0;
	logic [31:0] pwd = 0, rd_v, prd;
	logic [3:0] key = 0, hold = 4'h6, dc;
	logic [8:0] fk, led;
	logic [1:0] prof;
	logic rdy, gnd, nrc, sup, ftb, sef, t_o, c_o, h_o, rej;
	int n_mismatch = 0, samples_checked = 0;
	int m_gnd = 0, m_nrc = 0, m_sup = 0, m_prof = 0, i, s = 15;
	int m_on[3] = '{0, 0, 0}, m_map[3] = '{0, 0, 0};
	logic [11:0] sa[6] = '{12'h010, 12'h014, 12'h018, 12'h01C, 12'h020, 12'h028};
	int smin[6] = '{1, 0, 100, 10, 16, 5}, smax[6] = '{250, 3000, 1000, 320, 150, 200};
	always #25 mclk_i = ~mclk_i;
	always @(posedge mclk_i) if (rej === 1'b1) seen_rej <= seen_rej + 1;
	pfk_panel_model pm_u (.mclk_i(mclk_i), .go_i(go), .key_i(key), .hold_i(hold),
		.change_key_o(chg), .func_key_o(fk), .disc_cmd_o(dc));
	pfk_ctrl #(.CHG_WIN_CYC(50)) dut_u (.mclk_i(mclk_i), .rstn_i(rstn_i),
		.psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa),
		.pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err),
		.change_key_i(chg), .func_key_i(fk), .disc_cmd_i(dc), .trip_pb_i(trip),
		.close_pb_i(clo), .hot_tag_i(hot), .key_led_o(led),
		.ground_sense_inhibit_o(gnd), .reclose_inhibit_o(nrc), .sup_off_o(sup),
		.profile_o(prof), .fast_curve_en_o(), .delayed_curve_only_o(ftb),
		.sef_en_o(sef), .opt_func_en_o(ofe), .trip_o(t_o), .close_o(c_o),
		.hot_tag_o(h_o), .disc_rejected_o(rej));
	function automatic int lfsr(input int v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= d;
		@(posedge mclk_i) pen <= 1'b1;
		@(posedge mclk_i);
		while (rdy !== 1'b1 && n < 100) begin n++; @(posedge mclk_i); end
		if (n == 100) n_mismatch++;
		rd_v = prd;
		psel <= 1'b0; pen <= 1'b0;
		@(posedge mclk_i);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0); chk("read", e, rd_v);
		chk("slverr", 0, err);
	endtask
	task automatic press(input int k);
		key <= 4'(k); go <= 1'b1;
		@(posedge mclk_i) go <= 1'b0;
		repeat (14) @(posedge mclk_i);
	endtask
	task automatic ptog(input int k);
		press(9); press(k);
	endtask
	task automatic cmp();
		logic [8:0] e;
		logic f, sf;
		logic [9:1] o;
		e = {6'h00, m_sup[0], m_nrc[0], m_gnd[0]}; f = 0; sf = 0; o = '0;
		for (int j = 0; j < 3; j++) begin
			if (m_on[j] != 0 && m_map[j] != 0) o[m_map[j]] = 1'b1;
			e[3 + j] = (m_prof == j + 1);
			e[6 + j] = m_on[j] != 0 && m_map[j] != 0;
			f |= m_on[j] != 0 && m_map[j] == 4;
			sf |= m_on[j] != 0 && m_map[j] == 1;
		end
		chk("leds", e, led); chk("gnd", m_gnd, gnd); chk("nrc", m_nrc, nrc);
		chk("prof", m_prof, prof); chk("ftb", f, ftb); chk("sef", sf, sef);
		chk("sup", m_sup, sup);
		chk("opt", o, ofe);
		rd(12'h00C, {m_prof[1:0], e});
	endtask
	initial begin
		repeat (4) @(posedge mclk_i);
		rstn_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		cmp(); rd(12'h008, 0); rd(12'h0FC, 0);
		for (i = 0; i < 6; i++) begin
			xfer(1'b1, sa[i], 0); rd(sa[i], smin[i]);
			xfer(1'b1, sa[i], 32'hFFFF); rd(sa[i], smax[i]);
		end
		xfer(1'b1, 12'h024, 32'hFFFF); rd(12'h024, 300);
		xfer(1'b1, 12'h024, 32'h57); rd(12'h024, 80);
		s = lfsr(s); xfer(1'b1, 12'h010, s % 250 + 1); rd(12'h010, s % 250 + 1);
		xfer(1'b1, 12'h004, 32'h10); m_gnd = 1; cmp();
		xfer(1'b1, 12'h004, 32'h12); cmp();
		press(1); cmp();
		ptog(1); m_nrc = 1; press(1); cmp();
		press(9); rd(12'h000, 2); repeat (70) @(posedge mclk_i);
		press(0); cmp(); rd(12'h000, 0);
		press(13); m_nrc = 0; cmp();
		ptog(4); m_prof = 2; cmp(); ptog(4); m_prof = 0; cmp();
		xfer(1'b1, 12'h004, 32'h13); m_prof = 1; cmp();
		ptog(5); m_prof = 3; cmp();
		xfer(1'b1, 12'h004, 32'h05); m_prof = 0; cmp();
		xfer(1'b1, 12'h008, 32'hA14); m_map = '{4, 1, 0}; rd(12'h008, 32'h14);
		for (i = 0; i < 3; i++) begin
			ptog(6 + i); m_on[i] = 1; cmp();
		end
		ptog(2); m_sup = 1; rd(12'h000, 1); cmp();
		xfer(1'b1, 12'h004, 32'h8000_0000); cmp();
		chk("rej", 1, seen_rej);
		xfer(1'b1, 12'h004, 32'h0); m_gnd = 0; cmp();
		press(10); cmp(); chk("rej", 2, seen_rej);
		for (i = 0; i < 8; i++) begin
			s = lfsr(s);
			trip <= s[0]; clo <= s[1]; hot <= s[2];
			@(posedge mclk_i);
			@(posedge mclk_i) chk("pb", s[2:0], {h_o, c_o, t_o});
		end
		summarize();
	end
	initial begin
		repeat (20000) @(posedge mclk_i);
		n_mismatch++;
		summarize();
	end
endmodule // pfk_ctrl_tb_top

// File: bench/pfk_panel_model.sv
// Purpose: operator keys and discrete inputs
// Assumes: codes 0..8 function, 9 change, 10..13 discrete
// Notes: one key held for hold_i cycles
module pfk_panel_model (
	input wire logic mclk_i,
	input wire logic go_i,
	input wire logic [3:0] key_i,
	input wire logic [3:0] hold_i,
	output logic change_key_o,
	output logic [8:0] func_key_o,
	output logic [3:0] disc_cmd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [13:0] pins_r = 14'h0000;
	int hold = 0;
	always @(posedge mclk_i) begin
		if (go_i) begin
			pins_r <= 14'(1) << key_i;
			hold <= int'(hold_i);
		end else if (hold > 0) begin
			hold <= hold - 1;
			if (hold == 1)
				pins_r <= 14'h0000;
		end
	end
	assign change_key_o = pins_r[9];
	assign func_key_o = pins_r[8:0];
	assign disc_cmd_o = pins_r[13:10];
endmodule // pfk_panel_model

// File: design/pfk_ctrl.sv
// Purpose: operator panel function keys, latched functions and settings
// Assumes: keys are level pins, remote commands are apb writes
// Notes: remote commands at CMD; bit31 marks a source as supervisory
//
// The APB slave port and the register offsets are this design's own decisions.
`include "pfk_defines.svh"
// Overview of operation
// RULE_01 - nine keys, local or remote activation
// RULE_02 - leds show state from any source
// RULE_03 - change key then function key within 10s
// RULE_04 - one change ends change mode
// RULE_05 - change mode times out unchanged
// RULE_06 - ground trip block suppresses ground sensing
// RULE_07 - non-reclosing inhibits reclose, curve unchanged
// RULE_08 - supervisory off rejects rear and discrete commands
// RULE_09 - front port always works
// RULE_10 - supervisory off set from panel only
// RULE_11 - data and metering still readable
// RULE_12 - trip, close, hot line tag unaffected
// RULE_13 - four profiles, exactly one active
// RULE_14 - normal profile when no alternate led
// RULE_15 - alternate key toggles profile select
// RULE_16 - profiles selectable by remote command
// RULE_17 - options map to nine functions, none default
// RULE_18 - fast trip blocked uses delayed curve only
// RULE_19 - sef pickup from 0.5 A, 0.1 A steps
// RULE_20 - time multiplier 0.1 to 25 step 0.1
// RULE_21 - time adder 0 to 30 s step 0.01
// RULE_22 - minimum response 0.1 to 1 s step 0.001
// RULE_23 - high current multiplier 1 to 32 step 0.1
// RULE_24 - high current delay 0.016 to 0.150 s
// RULE_25 - time dial reset 0.1 to 30 s step 1
module pfk_ctrl #(
	parameter int unsigned CHG_WIN_CYC = `PFK_CHG_WIN_CYC
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic change_key_i,
	input wire logic [8:0] func_key_i,
	input wire logic [3:0] disc_cmd_i,
	input wire logic trip_pb_i,
	input wire logic close_pb_i,
	input wire logic hot_tag_i,
	output logic [8:0] key_led_o,
	output logic ground_sense_inhibit_o,
	output logic reclose_inhibit_o,
	output logic sup_off_o,
	output logic [1:0] profile_o,
	output logic fast_curve_en_o,
	output logic delayed_curve_only_o,
	output logic sef_en_o,
	output logic [9:1] opt_func_en_o,
	output logic trip_o,
	output logic close_o,
	output logic hot_tag_o,
	output logic disc_rejected_o
);
	import pfk_pkg::*;

	typedef struct packed {
		logic [2:0] chg_s;
		logic [26:0] fk_s;
		logic [11:0] dc_s;
		logic chg_k;
		logic [8:0] fk_k;
		logic [3:0] dc_k;
		pfk_mode_type mode;
		logic [31:0] tmr;
		logic gnd;
		logic nrc;
		logic sup;
		logic [1:0] prof;
		logic [2:0] opt_on;
		pfk_opt_type [2:0] opt_map;
		logic [15:0] tmul;
		logic [15:0] tadd;
		logic [15:0] mrt;
		logic [15:0] hctm;
		logic [15:0] hctd;
		logic [15:0] tdr;
		logic [15:0] sef;
		logic [31:0] rdata;
		logic rej;
	} pfk_st_type;

	pfk_st_type st_r;
	pfk_st_type st_nxt;
	logic [1:0] rst_sync_r;
	logic rst_n;
	logic [8:0] fk_edge;
	logic chg_edge;
	logic [3:0] dc_edge;
	logic wr;
	logic rd;
	logic [8:0] led;
	logic [9:1] opt_en;

	function automatic logic [15:0] clampv(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// apply one function command; key index k, set or clear
	function automatic pfk_st_type apply(input pfk_st_type s,
		input logic [3:0] k, input logic on);
		pfk_st_type t;
		t = s;
		if (k == `PFK_K_GND) begin
			t.gnd = on; // [RULE_06]
		end else if (k == `PFK_K_NRC) begin
			t.nrc = on; // [RULE_07]
		end else if (k == `PFK_K_SUP) begin
			t.sup = on;
		end else if (k >= `PFK_K_AP1 && k < `PFK_K_OP1) begin
			// one profile at a time; reselect returns to normal [RULE_13]
			if (on && s.prof != 2'(k - `PFK_K_AP1 + 4'h1)) begin
				t.prof = 2'(k - `PFK_K_AP1 + 4'h1); // [RULE_15]
			end else if (s.prof == 2'(k - `PFK_K_AP1 + 4'h1)) begin
				t.prof = 2'h0; // [RULE_14]
			end
		end else if (k < 4'h9) begin
			t.opt_on[2'(k - `PFK_K_OP1)] = on;
		end
		apply = t;
	endfunction

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// edges only when 2nd and 3rd sync stages agree on a new level
	assign chg_edge = (st_r.chg_s[1] == st_r.chg_s[2]) &&
		st_r.chg_s[2] && !st_r.chg_k;
	always_comb begin
		for (int i = 0; i < 9; i++) begin
			fk_edge[i] = (st_r.fk_s[3*i+1] == st_r.fk_s[3*i+2]) &&
				st_r.fk_s[3*i+2] && !st_r.fk_k[i];
		end
		for (int i = 0; i < 4; i++) begin
			dc_edge[i] = (st_r.dc_s[3*i+1] == st_r.dc_s[3*i+2]) &&
				st_r.dc_s[3*i+2] && !st_r.dc_k[i];
		end
	end

	assign wr = psel_i && penable_i && pwrite_i;
	assign rd = psel_i && !penable_i && !pwrite_i;

	always_comb begin
		opt_en = '0;
		for (int i = 0; i < 3; i++) begin
			if (st_r.opt_map[i] != 4'h0 && st_r.opt_on[i]) begin
				opt_en[st_r.opt_map[i]] = 1'b1; // [RULE_17]
			end
		end
		led[0] = st_r.gnd; // [RULE_02]
		led[1] = st_r.nrc;
		led[2] = st_r.sup;
		for (int i = 0; i < 3; i++) begin
			led[3+i] = (st_r.prof == 2'(i + 1)); // [RULE_14]
			led[6+i] = (st_r.opt_map[i] != 4'h0) && st_r.opt_on[i];
		end
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.rej = 1'b0;
		st_nxt.chg_s = {st_r.chg_s[1:0], change_key_i};
		for (int i = 0; i < 9; i++) begin
			st_nxt.fk_s[3*i +: 3] = {st_r.fk_s[3*i +: 2], func_key_i[i]};
		end
		for (int i = 0; i < 4; i++) begin
			st_nxt.dc_s[3*i +: 3] = {st_r.dc_s[3*i +: 2], disc_cmd_i[i]};
		end
		if (st_r.chg_s[1] == st_r.chg_s[2]) begin
			st_nxt.chg_k = st_r.chg_s[2];
		end
		for (int i = 0; i < 9; i++) begin
			if (st_r.fk_s[3*i+1] == st_r.fk_s[3*i+2]) begin
				st_nxt.fk_k[i] = st_r.fk_s[3*i+2];
			end
		end
		for (int i = 0; i < 4; i++) begin
			if (st_r.dc_s[3*i+1] == st_r.dc_s[3*i+2]) begin
				st_nxt.dc_k[i] = st_r.dc_s[3*i+2];
			end
		end
		// panel change mode
		case (st_r.mode)
			PFK_IDLE: begin
				if (chg_edge) begin
					st_nxt.mode = PFK_CHANGE; // [RULE_03]
					st_nxt.tmr = CHG_WIN_CYC - 1;
				end
			end
			PFK_CHANGE: begin
				if (fk_edge != 9'h000) begin
					for (int i = 8; i >= 0; i--) begin
						if (fk_edge[i]) begin
							st_nxt = apply(st_nxt, 4'(i), !led[i]); // [RULE_01]
						end
					end
					st_nxt.mode = PFK_IDLE; // [RULE_04]
				end else if (st_r.tmr == 32'h0) begin
					st_nxt.mode = PFK_IDLE; // [RULE_05]
				end else begin
					st_nxt.tmr = st_r.tmr - 32'h1;
				end
			end
			default: st_nxt.mode = PFK_IDLE;
		endcase
		// discrete inputs: ground on/off, nonreclose on/off
		for (int i = 0; i < 4; i++) begin
			if (dc_edge[i]) begin
				if (st_r.sup) begin
					st_nxt.rej = 1'b1; // [RULE_08]
				end else begin
					st_nxt = apply(st_nxt, 4'(i >> 1), !i[0]);
				end
			end
		end
		// remote command word: [3:0] key, [4] on, [31] rear supervisory
		if (wr && paddr_i == `PFK_A_CMD) begin
			if (pwdata_i[31] && st_r.sup) begin
				st_nxt.rej = 1'b1; // [RULE_08]
			end else if (pwdata_i[3:0] != `PFK_K_SUP) begin
				// front port (bit31 low) passes regardless [RULE_09]
				st_nxt = apply(st_nxt, pwdata_i[3:0], pwdata_i[4]); // [RULE_16]
			end
			// supervisory off never taken remotely [RULE_10]
		end else if (wr && paddr_i == `PFK_A_OPTMAP) begin
			for (int i = 0; i < 3; i++) begin
				st_nxt.opt_map[i] = (pwdata_i[4*i +: 4] > 4'h9) ?
					4'h0 : pwdata_i[4*i +: 4];
			end
		end else if (wr && paddr_i == `PFK_A_TMUL) begin
			st_nxt.tmul = clampv(pwdata_i[15:0], `PFK_TMUL_MIN,
				`PFK_TMUL_MAX); // [RULE_20]
		end else if (wr && paddr_i == `PFK_A_TADD) begin
			st_nxt.tadd = clampv(pwdata_i[15:0], `PFK_TADD_MIN,
				`PFK_TADD_MAX); // [RULE_21]
		end else if (wr && paddr_i == `PFK_A_MRT) begin
			st_nxt.mrt = clampv(pwdata_i[15:0], `PFK_MRT_MIN,
				`PFK_MRT_MAX); // [RULE_22]
		end else if (wr && paddr_i == `PFK_A_HCTM) begin
			st_nxt.hctm = clampv(pwdata_i[15:0], `PFK_HCTM_MIN,
				`PFK_HCTM_MAX); // [RULE_23]
		end else if (wr && paddr_i == `PFK_A_HCTD) begin
			st_nxt.hctd = clampv(pwdata_i[15:0], `PFK_HCTD_MIN,
				`PFK_HCTD_MAX); // [RULE_24]
		end else if (wr && paddr_i == `PFK_A_TDR) begin
			// tenths of a second, snapped to whole seconds above 0.1
			st_nxt.tdr = clampv((pwdata_i[15:0] < `PFK_TDR_STEP) ?
				`PFK_TDR_MIN : pwdata_i[15:0] - (pwdata_i[15:0] %
				`PFK_TDR_STEP), `PFK_TDR_MIN, `PFK_TDR_MAX); // [RULE_25]
		end else if (wr && paddr_i == `PFK_A_SEF) begin
			st_nxt.sef = clampv(pwdata_i[15:0], `PFK_SEF_MIN,
				`PFK_SEF_MAX); // [RULE_19]
		end
		// read data always served, supervisory off or not [RULE_11]
		if (rd) begin
			if (paddr_i == `PFK_A_CTRL) begin
				st_nxt.rdata = {30'h0, st_r.mode == PFK_CHANGE, st_r.sup};
			end else if (paddr_i == `PFK_A_OPTMAP) begin
				st_nxt.rdata = {20'h0, st_r.opt_map[2], st_r.opt_map[1],
					st_r.opt_map[0]};
			end else if (paddr_i == `PFK_A_STAT) begin
				st_nxt.rdata = {21'h0, st_r.prof, led};
			end else if (paddr_i == `PFK_A_TMUL) begin
				st_nxt.rdata = {16'h0, st_r.tmul};
			end else if (paddr_i == `PFK_A_TADD) begin
				st_nxt.rdata = {16'h0, st_r.tadd};
			end else if (paddr_i == `PFK_A_MRT) begin
				st_nxt.rdata = {16'h0, st_r.mrt};
			end else if (paddr_i == `PFK_A_HCTM) begin
				st_nxt.rdata = {16'h0, st_r.hctm};
			end else if (paddr_i == `PFK_A_HCTD) begin
				st_nxt.rdata = {16'h0, st_r.hctd};
			end else if (paddr_i == `PFK_A_TDR) begin
				st_nxt.rdata = {16'h0, st_r.tdr};
			end else if (paddr_i == `PFK_A_SEF) begin
				st_nxt.rdata = {16'h0, st_r.sef};
			end else begin
				st_nxt.rdata = 32'h0;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_r.chg_s <= '0;
			st_r.fk_s <= '0;
			st_r.dc_s <= '0;
			st_r.chg_k <= 1'b0;
			st_r.fk_k <= '0;
			st_r.dc_k <= '0;
			st_r.mode <= PFK_IDLE;
			st_r.tmr <= '0;
			st_r.gnd <= 1'b0;
			st_r.nrc <= 1'b0;
			st_r.sup <= 1'b0;
			st_r.prof <= 2'h0;
			st_r.opt_on <= '0;
			st_r.opt_map <= '0; // [RULE_17]
			st_r.tmul <= `PFK_TMUL_MIN;
			st_r.tadd <= `PFK_TADD_MIN;
			st_r.mrt <= `PFK_MRT_MIN;
			st_r.hctm <= `PFK_HCTM_MIN;
			st_r.hctd <= `PFK_HCTD_MIN;
			st_r.tdr <= `PFK_TDR_MIN;
			st_r.sef <= `PFK_SEF_MIN;
			st_r.rdata <= '0;
			st_r.rej <= 1'b0;
		end else begin
			st_r.chg_s <= st_nxt.chg_s;
			st_r.fk_s <= st_nxt.fk_s;
			st_r.dc_s <= st_nxt.dc_s;
			st_r.chg_k <= st_nxt.chg_k;
			st_r.fk_k <= st_nxt.fk_k;
			st_r.dc_k <= st_nxt.dc_k;
			st_r.mode <= st_nxt.mode;
			st_r.tmr <= st_nxt.tmr;
			st_r.gnd <= st_nxt.gnd;
			st_r.nrc <= st_nxt.nrc;
			st_r.sup <= st_nxt.sup;
			st_r.prof <= st_nxt.prof;
			st_r.opt_on <= st_nxt.opt_on;
			st_r.opt_map <= st_nxt.opt_map;
			st_r.tmul <= st_nxt.tmul;
			st_r.tadd <= st_nxt.tadd;
			st_r.mrt <= st_nxt.mrt;
			st_r.hctm <= st_nxt.hctm;
			st_r.hctd <= st_nxt.hctd;
			st_r.tdr <= st_nxt.tdr;
			st_r.sef <= st_nxt.sef;
			st_r.rdata <= st_nxt.rdata;
			st_r.rej <= st_nxt.rej;
		end
	end

	assign prdata_o = st_r.rdata;
	assign pready_o = 1'b1;
	assign pslverr_o = 1'b0;
	assign key_led_o = led; // [RULE_02]
	assign ground_sense_inhibit_o = st_r.gnd; // [RULE_06]
	assign reclose_inhibit_o = st_r.nrc; // [RULE_07]
	assign sup_off_o = st_r.sup;
	assign profile_o = st_r.prof; // [RULE_13]
	assign fast_curve_en_o = !opt_en[`PFK_OPT_FTB]; // [RULE_18]
	assign delayed_curve_only_o = opt_en[`PFK_OPT_FTB]; // [RULE_18]
	assign sef_en_o = opt_en[`PFK_OPT_SEF]; // [RULE_19]
	assign opt_func_en_o = opt_en;
	// direct paths, independent of supervisory off [RULE_12]
	assign trip_o = trip_pb_i;
	assign close_o = close_pb_i;
	assign hot_tag_o = hot_tag_i;
	assign disc_rejected_o = st_r.rej;
endmodule // pfk_ctrl

// File: design/pfk_defines.svh
// Purpose: constants for the panel function key controller
// Assumes: 20 MHz clock, APB register access
// Notes: settings are held in fixed-point units of their step, except time dial reset: tenths of a second, 1 s step
`ifndef PFK_DEFINES_SVH
`define PFK_DEFINES_SVH
`define PFK_CHG_WIN_MS 10000
`define PFK_CLK_KHZ 20000
`define PFK_CHG_WIN_CYC (`PFK_CHG_WIN_MS * `PFK_CLK_KHZ)
`define PFK_A_CTRL 12'h000
`define PFK_A_CMD 12'h004
`define PFK_A_OPTMAP 12'h008
`define PFK_A_STAT 12'h00C
`define PFK_A_TMUL 12'h010
`define PFK_A_TADD 12'h014
`define PFK_A_MRT 12'h018
`define PFK_A_HCTM 12'h01C
`define PFK_A_HCTD 12'h020
`define PFK_A_TDR 12'h024
`define PFK_A_SEF 12'h028
`define PFK_TMUL_MIN 16'h0001
`define PFK_TMUL_MAX 16'h00FA
`define PFK_TADD_MIN 16'h0000
`define PFK_TADD_MAX 16'h0BB8
`define PFK_MRT_MIN 16'h0064
`define PFK_MRT_MAX 16'h03E8
`define PFK_HCTM_MIN 16'h000A
`define PFK_HCTM_MAX 16'h0140
`define PFK_HCTD_MIN 16'h0010
`define PFK_HCTD_MAX 16'h0096
`define PFK_TDR_MIN 16'h0001
`define PFK_TDR_MAX 16'h012C
`define PFK_TDR_STEP 16'h000A
`define PFK_SEF_MIN 16'h0005
`define PFK_SEF_MAX 16'h00C8
`define PFK_K_GND 4'h0
`define PFK_K_NRC 4'h1
`define PFK_K_SUP 4'h2
`define PFK_K_AP1 4'h3
`define PFK_K_OP1 4'h6
`define PFK_OPT_FTB 4'h4
`define PFK_OPT_SEF 4'h1
`endif

// File: design/pfk_pkg.sv
// Purpose: types for the panel function key controller
// Assumes: nothing
// Notes: option codes 1..9, 0 means unassigned
package pfk_pkg;
	typedef enum logic [1:0] {
		PFK_IDLE = 2'b00,
		PFK_CHANGE = 2'b01
	} pfk_mode_type;
	typedef logic [3:0] pfk_opt_type;
endpackage
